// ---- nsbi_top.sv ----
// Processor-side non-pendant system bus interface unit.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - Pipeline clock multiplier is one of eleven selectable factors from 2 to 9.
// - Addresses and data share a 64-bit bus with 9-bit command and 8-bit check.
// - The driver of a data cycle places byte parity on the check bus.
// - Command parity is ignored on input and driven zero on output.
// - Command marks address or data, read/write, last word and error.
// - Command bus is two-way for device and external requests.
// - Low three address bits give start byte; command gives byte count; blocks allowed.
// - Agent signals read/write readiness; device samples before dropping the address.
// - Agent requests the buses; device grants with the handover output.
// - Outbound valid only while device drives valid address or data.
// - At most two reads outstanding, completed in either order.
// - Device requests the bus back to issue a second read.
// - After the grant the device drives the second read then releases again.
// - Each swap cycle toggles assumed return order; default is issue order.
// - Read kind is high for instruction fetch, low for data read.
// - Outgoing rate set by boot mode bits; incoming rate set by the agent.
module nsbi_top
  import nsbi_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Boot-time mode bits.
  input wire logic [3:0] i_clk_mult,
  input wire logic [1:0] i_tx_rate,
  // Core request side.
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire nsbi_req_t i_req,
  // Core response side.
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output nsbi_rsp_t o_rsp,
  output logic [3:0] o_pipe_mult,
  // System bus pins.
  input wire logic [NSBI_AD_W-1:0] i_sys_addr_data_bus,
  output logic [NSBI_AD_W-1:0] o_sys_addr_data_bus,
  output logic o_sys_addr_data_bus_oe,
  input wire logic [NSBI_CHK_W-1:0] i_addr_data_check_bits,
  output logic [NSBI_CHK_W-1:0] o_addr_data_check_bits,
  output logic o_addr_data_check_bits_oe,
  input wire logic [NSBI_CMD_W-1:0] i_cmd_ident_bus,
  output logic [NSBI_CMD_W-1:0] o_cmd_ident_bus,
  output logic o_cmd_ident_bus_oe,
  input wire logic i_cmd_parity_pin,
  output logic o_cmd_parity_pin,
  output logic o_cmd_parity_pin_oe,
  // Handshake pins.
  input wire logic i_read_accept_ready_n,
  input wire logic i_write_accept_ready_n,
  input wire logic i_external_bus_request_n,
  output logic o_release_n,
  input wire logic i_inbound_qualifier_n,
  output logic o_outbound_qualifier_n,
  output logic o_processor_bus_request_n,
  input wire logic i_processor_bus_grant_n,
  input wire logic i_response_order_swap_n,
  output logic o_read_kind
);
  //////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.
  logic [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // Handshake pins pass three flops; a change counts once stages two and three agree.
  localparam int NSYN = 6;
  wire [NSYN-1:0] pin_raw = {i_read_accept_ready_n, i_write_accept_ready_n, i_external_bus_request_n,
                             i_inbound_qualifier_n, i_processor_bus_grant_n, i_response_order_swap_n};
  logic [NSYN-1:0] syn1, syn2, syn3, pin_f;
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syn1 <= '1;
      syn2 <= '1;
      syn3 <= '1;
      pin_f <= '1;
    end
    else
    begin
      syn1 <= pin_raw;
      syn2 <= syn1;
      syn3 <= syn2;
      pin_f <= (syn2 & syn3) | (pin_f & (syn2 ^ syn3));
    end
  end
  wire rd_rdy = !pin_f[5];
  wire wr_rdy = !pin_f[4];
  wire ext_req = !pin_f[3];
  // Qualifier and swap are one-cycle pulses that the agreement filter would swallow.
  // They are taken from the third stage instead, in step with the delayed bus words.
  wire vin = !syn3[2];
  wire grant = !pin_f[1];
  wire swap = !syn3[0];
  // Bus data matched to the delayed qualifier.
  logic [NSBI_AD_W-1:0] ad_d1, ad_d2, ad_d3;
  logic [NSBI_CMD_W-1:0] cmd_d1, cmd_d2, cmd_d3;

  //////////////////////////////////////////////////////////////////////////////
  // Parity, mode bits and state.
  function automatic logic [NSBI_CHK_W-1:0] byte_par(input logic [NSBI_AD_W-1:0] d);
    logic [NSBI_CHK_W-1:0] p;
    p = '0;
    for (int i = 0; i < NSBI_CHK_W; i++)
      p[i] = ^d[i*8 +: 8];
    return p;
  endfunction

  // Multiplier is caught after reset release; the pipeline PLL itself lives outside.
  logic [3:0] pipe_mult;
  logic mult_caught;
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pipe_mult <= NSBI_MULT_RST;
      mult_caught <= 1'b0;
    end
    else if (!mult_caught)
    begin
      pipe_mult <= (i_clk_mult > 4'(NSBI_MUL_9P0)) ? NSBI_MULT_RST : i_clk_mult;
      mult_caught <= 1'b1;
    end
  end

  nsbi_state_t state, next_state;
  logic [1:0] outstanding;
  logic order_swapped;
  logic first_tag;
  logic [1:0] pace;
  wire pace_ok = (pace == i_tx_rate);

  wire req_is_rd = i_req_valid && !i_req.write;
  wire can_read = req_is_rd && rd_rdy && (outstanding < 2'd2);
  wire can_write = i_req_valid && i_req.write && wr_rdy && (outstanding == 2'd0);
  wire own_bus = (state == NSBI_ST_IDLE);
  wire start = own_bus && pace_ok && !ext_req && (can_read || can_write);
  wire start2 = (state == NSBI_ST_PREQ) && grant && pace_ok && can_read;
  wire in_word = vin && !own_bus && cmd_d3[NSBI_CMD_DATA_BIT];
  wire in_last = in_word && cmd_d3[NSBI_CMD_LAST_BIT];
  wire fifo_ready;

  wire [NSBI_CMD_W-1:0] addr_cmd = {1'b0, i_req.write, 3'b000, i_req.block, i_req.size};
  wire [NSBI_CMD_W-1:0] data_cmd = NSBI_CMD_W'(1) << NSBI_CMD_DATA_BIT | NSBI_CMD_W'(1) << NSBI_CMD_LAST_BIT;

  // Done completions: when one read finishes, its tag leaves; the other read becomes first.
  wire done_tag = first_tag ^ order_swapped;

  always_comb
  begin
    next_state = state;
    unique case (state)
      NSBI_ST_IDLE:
        if (start)
          next_state = NSBI_ST_ADDR;
        else if (ext_req)
          next_state = NSBI_ST_EXT;
      NSBI_ST_ADDR:
        next_state = i_req.write ? NSBI_ST_WDATA : NSBI_ST_RELEASED;
      NSBI_ST_WDATA:
        next_state = NSBI_ST_IDLE;
      NSBI_ST_RELEASED:
        if (outstanding == 2'd0)
          next_state = NSBI_ST_IDLE;
        else if (outstanding == 2'd1 && req_is_rd && !in_last)
          next_state = NSBI_ST_PREQ;
      NSBI_ST_PREQ:
        if (start2)
          next_state = NSBI_ST_ADDR;
      NSBI_ST_EXT:
        if (!ext_req && outstanding == 2'd0)
          next_state = NSBI_ST_IDLE;
      default:
        next_state = NSBI_ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus drive and bookkeeping.
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= NSBI_ST_IDLE;
      outstanding <= 2'd0;
      order_swapped <= 1'b0;
      first_tag <= 1'b0;
      pace <= 2'd0;
      o_sys_addr_data_bus <= '0;
      o_addr_data_check_bits <= '0;
      o_cmd_ident_bus <= NSBI_CMD_RST;
      o_sys_addr_data_bus_oe <= 1'b1;
      o_outbound_qualifier_n <= 1'b1;
      o_release_n <= 1'b1;
      o_processor_bus_request_n <= 1'b1;
      o_read_kind <= 1'b0;
      o_req_ready <= 1'b0;
      ad_d1 <= '0;
      ad_d2 <= '0;
      ad_d3 <= '0;
      cmd_d1 <= NSBI_CMD_RST;
      cmd_d2 <= NSBI_CMD_RST;
      cmd_d3 <= NSBI_CMD_RST;
    end
    else
    begin
      state <= next_state;
      pace <= pace_ok ? 2'd0 : pace + 2'd1;
      ad_d1 <= i_sys_addr_data_bus;
      ad_d2 <= ad_d1;
      ad_d3 <= ad_d2;
      cmd_d1 <= i_cmd_ident_bus;
      cmd_d2 <= cmd_d1;
      cmd_d3 <= cmd_d2;
      o_req_ready <= 1'b0;
      o_outbound_qualifier_n <= 1'b1;
      o_read_kind <= 1'b0;
      if (start || start2)
      begin
        o_sys_addr_data_bus <= i_req.addr;
        o_addr_data_check_bits <= byte_par(i_req.addr);
        o_cmd_ident_bus <= addr_cmd;
        o_outbound_qualifier_n <= 1'b0;
        o_read_kind <= !i_req.write && i_req.ifetch;
        o_req_ready <= !i_req.write;
        o_processor_bus_request_n <= 1'b1;
      end
      else if (state == NSBI_ST_ADDR && i_req.write)
      begin
        o_sys_addr_data_bus <= i_req.wdata;
        o_addr_data_check_bits <= byte_par(i_req.wdata);
        o_cmd_ident_bus <= data_cmd;
        o_outbound_qualifier_n <= 1'b0;
        o_req_ready <= 1'b1;
      end
      // Bus is handed over after a read address, or on an external request while idle.
      o_sys_addr_data_bus_oe <= (next_state == NSBI_ST_IDLE) || (next_state == NSBI_ST_ADDR)
                                || (next_state == NSBI_ST_WDATA);
      o_release_n <= !((next_state == NSBI_ST_RELEASED && state == NSBI_ST_ADDR)
                       || (next_state == NSBI_ST_EXT && state == NSBI_ST_IDLE));
      if (next_state == NSBI_ST_PREQ)
        o_processor_bus_request_n <= 1'b0;
      // Each swap cycle reverses the order; the last return word of a read retires it.
      if (swap)
        order_swapped <= !order_swapped;
      if (start || start2)
      begin
        if (!i_req.write)
        begin
          if (outstanding == 2'd0)
            first_tag <= 1'b0;
          outstanding <= outstanding + 2'd1 - 2'(in_last);
        end
      end
      else if (in_last && outstanding != 2'd0)
      begin
        outstanding <= outstanding - 2'd1;
        first_tag <= !done_tag;
        if (outstanding == 2'd1)
          order_swapped <= swap;
        else if (swap)
          order_swapped <= !order_swapped;
        else
          order_swapped <= 1'b0;
      end
    end
  end
  assign o_addr_data_check_bits_oe = o_sys_addr_data_bus_oe;
  assign o_cmd_ident_bus_oe = o_sys_addr_data_bus_oe;
  assign o_cmd_parity_pin = 1'b0;
  assign o_cmd_parity_pin_oe = o_sys_addr_data_bus_oe;
  assign o_pipe_mult = pipe_mult;

  //////////////////////////////////////////////////////////////////////////////
  // Returned read words go through the FIFO; a full FIFO only drops valid words counting.
  nsbi_rsp_t rsp_in;
  assign rsp_in = '{tag: done_tag, last: cmd_d3[NSBI_CMD_LAST_BIT], err: cmd_d3[NSBI_CMD_ERR_BIT],
                    data: ad_d3};
  nsbi_fifo #(.WIDTH(NSBI_RSP_W), .DEPTH(NSBI_FIFO_DEPTH)) u_rsp_fifo
  (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_in_valid(in_word),
    .o_in_ready(fifo_ready),
    .i_in_data(rsp_in),
    .o_out_valid(o_rsp_valid),
    .i_out_ready(i_rsp_ready),
    .o_out_data(o_rsp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_cmd_parity_zero: assert property (@(posedge i_mclk) disable iff (!rst_n)
    o_cmd_parity_pin == 1'b0) else $error("command parity not zero");
  chk_valid_with_oe: assert property (@(posedge i_mclk) disable iff (!rst_n)
    !o_outbound_qualifier_n |-> o_sys_addr_data_bus_oe) else $error("valid without drive");
  chk_data_parity_ok: assert property (@(posedge i_mclk) disable iff (!rst_n)
    !o_outbound_qualifier_n |-> o_addr_data_check_bits == byte_par(o_sys_addr_data_bus))
    else $error("bad outbound parity");
  chk_two_reads_max: assert property (@(posedge i_mclk) disable iff (!rst_n)
    outstanding <= 2'd2) else $error("too many reads");
  chk_preq_one_read: assert property (@(posedge i_mclk) disable iff (!rst_n)
    !o_processor_bus_request_n |-> outstanding == 2'd1 || $past(grant)) else $error("bus request misuse");
  chk_swap_toggles: assert property (@(posedge i_mclk) disable iff (!rst_n)
    swap && !in_last && !start && !start2 |=> order_swapped != $past(order_swapped))
    else $error("swap did not toggle");
  chk_fetch_kind: assert property (@(posedge i_mclk) disable iff (!rst_n)
    o_read_kind |-> !o_outbound_qualifier_n && !o_cmd_ident_bus[NSBI_CMD_WRITE_BIT])
    else $error("read kind outside read address");
  chk_read_release: assert property (@(posedge i_mclk) disable iff (!rst_n)
    state == NSBI_ST_ADDR && !i_req.write |-> ##[0:1] !o_release_n) else $error("no release after read");
  chk_ext_grant: assert property (@(posedge i_mclk) disable iff (!rst_n)
    state == NSBI_ST_IDLE && ext_req && !start |=> !o_release_n) else $error("ext request not granted");
  cov_write: cover property (@(posedge i_mclk) state == NSBI_ST_ADDR ##1 state == NSBI_ST_WDATA);
  cov_second_read: cover property (@(posedge i_mclk) start2);
  cov_swap_two: cover property (@(posedge i_mclk) swap && outstanding == 2'd2);
  cov_fifo_full: cover property (@(posedge i_mclk) !fifo_ready);
endmodule

// ---- nsbi_pkg.sv ----
// Package holding shared constants and carrier types of the system bus interface unit.
package nsbi_pkg;
  localparam int NSBI_AD_W = 64;
  localparam int NSBI_CMD_W = 9;
  localparam int NSBI_CHK_W = 8;
  localparam int NSBI_FIFO_DEPTH = 32;
  // Command bus fields.
  localparam int NSBI_CMD_DATA_BIT = 8;
  localparam int NSBI_CMD_WRITE_BIT = 7;
  localparam int NSBI_CMD_LAST_BIT = 5;
  localparam int NSBI_CMD_ERR_BIT = 4;
  localparam int NSBI_CMD_BLOCK_BIT = 3;
  localparam int NSBI_CMD_SIZE_LSB = 0;
  localparam int NSBI_CMD_SIZE_W = 3;
  localparam int NSBI_BYTE_ADDR_W = 3;
  localparam logic [NSBI_CMD_W-1:0] NSBI_CMD_RST = 9'h000;
  localparam logic [3:0] NSBI_MULT_RST = 4'h0;
  localparam int NSBI_SWAP_LEAD_CYC = 2;

  // Pipeline clock multiplier codes, in half steps up to 5.0, then whole steps.
  typedef enum logic [3:0] {
    NSBI_MUL_2P0 = 4'h0, NSBI_MUL_2P5 = 4'h1, NSBI_MUL_3P0 = 4'h2, NSBI_MUL_3P5 = 4'h3,
    NSBI_MUL_4P0 = 4'h4, NSBI_MUL_4P5 = 4'h5, NSBI_MUL_5P0 = 4'h6, NSBI_MUL_6P0 = 4'h7,
    NSBI_MUL_7P0 = 4'h8, NSBI_MUL_8P0 = 4'h9, NSBI_MUL_9P0 = 4'ha
  } nsbi_mult_t;

  typedef enum logic [2:0] {
    NSBI_ST_IDLE = 3'b000,
    NSBI_ST_ADDR = 3'b001,
    NSBI_ST_WDATA = 3'b010,
    NSBI_ST_RELEASED = 3'b011,
    NSBI_ST_PREQ = 3'b100,
    NSBI_ST_EXT = 3'b101
  } nsbi_state_t;

  // One request from the processor core.
  typedef struct packed {
    logic write;
    logic ifetch;
    logic block;
    logic [NSBI_CMD_SIZE_W-1:0] size;
    logic [NSBI_AD_W-1:0] addr;
    logic [NSBI_AD_W-1:0] wdata;
  } nsbi_req_t;

  // One returned read word.
  typedef struct packed {
    logic tag;
    logic last;
    logic err;
    logic [NSBI_AD_W-1:0] data;
  } nsbi_rsp_t;

  localparam int NSBI_RSP_W = $bits(nsbi_rsp_t);
endpackage

// ---- nsbi_fifo.sv ----
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module nsbi_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Write side.
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Read side.
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end
endmodule

// ---- nsbi_mem_model.sv ----
// Behavioural memory controller that faces the system bus interface unit.
`timescale 1ns/100ps
module nsbi_mem_model
  import nsbi_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Bench controls.
  input wire logic i_go,
  input wire logic i_swap,
  input wire logic i_err,
  input wire logic i_busy,
  input wire logic [1:0] i_lat,
  // Device outputs.
  input wire logic [NSBI_AD_W-1:0] i_bus,
  input wire logic i_bus_oe,
  input wire logic [NSBI_CMD_W-1:0] i_cmd,
  input wire logic i_qual_n,
  input wire logic i_preq_n,
  // Agent outputs.
  output logic [NSBI_AD_W-1:0] o_bus,
  output logic [NSBI_CHK_W-1:0] o_chk,
  output logic [NSBI_CMD_W-1:0] o_cmd,
  output logic o_qual_n,
  output logic o_grant_n,
  output logic o_swap_n,
  output logic o_ready_n,
  output logic o_done
);
  logic [64:0] rd_q[$];
  logic [64:0] r;
  logic [63:0] d;

  function automatic logic [7:0] par(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      par[i] = ^v[8*i+:8];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  assign o_ready_n = i_busy;

  always @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn)
      rd_q.delete();
    else if (!i_qual_n && !i_cmd[8] && !i_cmd[7])
      rd_q.push_back({i_cmd[3], i_bus});

  // The grant is held until the request drops, since the device syncs it late.
  initial
  begin
    o_grant_n = 1'b1;
    forever
    begin
      @(posedge i_mclk);
      if (!i_preq_n && o_grant_n)
      begin
        repeat (i_lat) @(posedge i_mclk);
        #1 o_grant_n <= 1'b0;
      end
      else if (i_preq_n)
        #1 o_grant_n <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Idle lines toggle every cycle except during the swap and latency waits before a return, so a stale word never looks valid.
  initial
  begin
    o_bus = '0;
    o_chk = '0;
    o_cmd = '0;
    o_qual_n = 1'b1;
    o_swap_n = 1'b1;
    o_done = 1'b0;
    forever
    begin
      @(posedge i_mclk);
      #1;
      o_bus <= ~o_bus;
      o_chk <= ~o_chk;
      o_cmd <= ~o_cmd;
      o_qual_n <= 1'b1;
      o_swap_n <= 1'b1;
      if (!i_go)
        o_done <= 1'b0;
      else if (!o_done && !i_bus_oe && rd_q.size() > 0)
      begin
        if (i_swap && rd_q.size() == 2)
        begin
          o_swap_n <= 1'b0;
          rd_q.reverse();
          @(posedge i_mclk);
          #1 o_swap_n <= 1'b1;
          @(posedge i_mclk);
        end
        repeat (i_lat) @(posedge i_mclk);
        while (rd_q.size() > 0)
        begin
          r = rd_q.pop_front();
          for (int k = 0; k < (r[64] ? 4 : 1); k++)
          begin
            @(posedge i_mclk);
            #1;
            d = r[63:0] + 64'(k);
            o_bus <= d;
            o_chk <= par(d);
            o_qual_n <= 1'b0;
            o_cmd <= {1'b1, 2'h0, k == (r[64] ? 3 : 0), i_err && k == 0, 4'h0};
          end
        end
        o_done <= 1'b1;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the system bus interface unit.
`timescale 1ns/100ps
module tb_top;
  import nsbi_pkg::*;
  logic mclk, resetn, req_valid, rsp_ready, go, swap, err, busy, stall, parity_in;
  logic [3:0] clk_mult, pipe_mult;
  logic [1:0] lat;
  nsbi_req_t req;
  nsbi_rsp_t rsp;
  logic req_ready, rsp_valid, ad_oe, chk_oe, cmd_oe, cp_oe, cp_out, rel_n, qual_n, preq_n, read_kind;
  logic m_qual_n, grant_n, swap_n, ready_n, done, ext_req_n;
  logic [63:0] ad_out, ad_in, m_bus;
  logic [7:0] chk_out, chk_in, m_chk;
  logic [8:0] cmd_out, cmd_in, m_cmd;
  int miscompares, n_tests, cyc;
  nsbi_rsp_t got_q[$];
  logic [81:0] out_q[$];

  assign ad_in = ad_oe ? ad_out : m_bus;
  assign chk_in = chk_oe ? chk_out : m_chk;
  assign cmd_in = cmd_oe ? cmd_out : m_cmd;

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  nsbi_top u_nsbi_top (.i_mclk(mclk), .i_resetn(resetn), .i_clk_mult(clk_mult), .i_tx_rate(2'h2),
    .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req(req), .o_rsp_valid(rsp_valid),
    .i_rsp_ready(rsp_ready), .o_rsp(rsp), .o_pipe_mult(pipe_mult), .i_sys_addr_data_bus(ad_in),
    .o_sys_addr_data_bus(ad_out), .o_sys_addr_data_bus_oe(ad_oe), .i_addr_data_check_bits(chk_in),
    .o_addr_data_check_bits(chk_out), .o_addr_data_check_bits_oe(chk_oe), .i_cmd_ident_bus(cmd_in),
    .o_cmd_ident_bus(cmd_out), .o_cmd_ident_bus_oe(cmd_oe), .i_cmd_parity_pin(parity_in),
    .o_cmd_parity_pin(cp_out), .o_cmd_parity_pin_oe(cp_oe), .i_read_accept_ready_n(ready_n),
    .i_write_accept_ready_n(ready_n), .i_external_bus_request_n(ext_req_n), .o_release_n(rel_n),
    .i_inbound_qualifier_n(m_qual_n), .o_outbound_qualifier_n(qual_n), .o_processor_bus_request_n(preq_n),
    .i_processor_bus_grant_n(grant_n), .i_response_order_swap_n(swap_n), .o_read_kind(read_kind));

  nsbi_mem_model u_nsbi_mem_model (.i_mclk(mclk), .i_resetn(resetn), .i_go(go), .i_swap(swap), .i_err(err),
    .i_busy(busy), .i_lat(lat), .i_bus(ad_out), .i_bus_oe(ad_oe), .i_cmd(cmd_out), .i_qual_n(qual_n),
    .i_preq_n(preq_n), .o_bus(m_bus), .o_chk(m_chk), .o_cmd(m_cmd), .o_qual_n(m_qual_n), .o_grant_n(grant_n),
    .o_swap_n(swap_n), .o_ready_n(ready_n), .o_done(done));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] par(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      par[i] = ^v[8*i+:8];
  endfunction

  task automatic give_verdict;
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [81:0] exp, input logic [81:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  task automatic do_reset(input logic [3:0] m);
    clk_mult = m;
    resetn = 1'b0;
    repeat (20) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (6) tick();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // The agent holds off readiness for hold cycles; the request must wait for it.
  task automatic issue(input logic w, input logic f, input logic b, input logic [63:0] a, input int hold);
    int t;
    logic [81:0] g;
    busy = hold > 0;
    // The synchronised ready lags the pin by about four cycles.
    repeat (5) tick();
    req = '{write: w, ifetch: f, block: b, size: b ? 3'h0 : 3'($urandom_range(7)), addr: a,
      wdata: {$urandom, $urandom}};
    req_valid = 1'b1;
    t = 0;
    while (req_ready !== 1'b1 && t < 60)
    begin
      tick();
      t++;
      if (t == hold)
        busy = 1'b0;
    end
    req_valid = 1'b0;
    check("accept delay", 82'(t > hold && t < 60), 82'(1));
    tick();
    tick();
    g = out_q.size() > 0 ? out_q.pop_front() : '1;
    check("address word", {f & ~w, 1'b0, w, 3'h0, b, req.size, 8'h00, a},
      g & {10'h38f, 8'h00, {64{1'b1}}});
    if (w)
    begin
      g = out_q.size() > 0 ? out_q.pop_front() : '1;
      check("write word", {10'h120, par(req.wdata), req.wdata}, g & {10'h120, {72{1'b1}}});
    end
  endtask

  task automatic reads(input int n, input logic sw, input logic b);
    logic [63:0] a[2];
    nsbi_rsp_t e;
    int t, idx;
    got_q.delete();
    stall = b;
    err = 1'($urandom_range(1));
    for (int i = 0; i < n; i++)
    begin
      a[i] = {$urandom, $urandom};
      issue(1'b0, 1'($urandom_range(1)), b, a[i], 0);
    end
    t = 0;
    while (ad_oe !== 1'b0 && t++ < 40)
      tick();
    swap = sw;
    go = 1'b1;
    t = 0;
    while (done !== 1'b1 && t++ < 100)
      tick();
    go = 1'b0;
    stall = 1'b0;
    t = 0;
    while (got_q.size() < n * (b ? 4 : 1) && t++ < 200)
      tick();
    for (int j = 0; j < n; j++)
    begin
      idx = (sw && n == 2) ? 1 - j : j;
      for (int k = 0; k < (b ? 4 : 1); k++)
      begin
        e = '{tag: idx[0], last: k == (b ? 3 : 0), err: err && k == 0, data: a[idx] + 64'(k)};
        check("response", 82'(e), 82'(got_q.size() > 0 ? got_q.pop_front() : '1));
      end
    end
  endtask

  // The agent takes the idle buses and hands them back.
  task automatic ext_handover;
    int t;
    ext_req_n = 1'b0;
    t = 0;
    while (rel_n !== 1'b0 && t < 20)
    begin
      tick();
      t++;
    end
    check("handover pulse", 82'(1), 82'(t < 20));
    tick();
    check("bus handed over", 82'(0), 82'(ad_oe));
    ext_req_n = 1'b1;
    repeat (8) tick();
    check("bus taken back", 82'(1), 82'(ad_oe));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
    if (resetn && !qual_n)
      out_q.push_back({read_kind, cmd_out, chk_out, ad_out});

  always @(posedge mclk)
    if (rsp_valid && rsp_ready)
      got_q.push_back(rsp);

  always @(posedge mclk)
    if (resetn)
    begin
      if (!qual_n)
        check("drive with qualifier", 82'(1), 82'(ad_oe));
      check("command parity", 82'(0), 82'(cp_out));
    end

  always @(posedge mclk)
  begin
    #1;
    rsp_ready <= !stall && $urandom_range(3) != 0;
    parity_in <= 1'($urandom_range(1));
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  initial
  begin
    void'($urandom(25419));
    {resetn, req_valid, rsp_ready, go, swap, err, busy, stall, parity_in, lat} = '0;
    ext_req_n = 1'b1;
    clk_mult = 4'h0;
    req = '0;
    for (int m = 0; m < 12; m++)
    begin
      do_reset(m == 11 ? 4'hf : 4'(m));
      check("pipe mult", 82'(m == 11 ? 0 : m), 82'(pipe_mult));
    end
    for (int i = 0; i < 8; i++)
    begin
      lat = 2'($urandom_range(3));
      issue(1'b1, 1'b0, 1'b0, {$urandom, $urandom}, $urandom_range(3));
      reads(1 + $urandom_range(1), 1'($urandom_range(1)), 1'($urandom_range(1)));
    end
    ext_handover();
    reads(2, 1'b1, 1'b1);
    give_verdict();
  end
endmodule
